// file: pcm_pkg.sv
// Shared constants and types for the PCM switch matrix and its host port.
// Assumes a single 200 MHz pclk for both ends.
package pcm_pkg;
    localparam int         CLK_MHZ      = 200;
    localparam int         LINES        = 8;
    localparam int         SLOTS_E1     = 32;
    localparam int         SLOTS_T1     = 24;
    localparam logic [7:0] LAST_BIT_E1  = 8'(SLOTS_E1 * 8 - 1);
    localparam logic [7:0] LAST_BIT_T1  = 8'(SLOTS_T1 * 8 - 1);
    localparam logic [2:0] LAST_BITPOS  = 3'h7;
    localparam logic       MCK_LAST_PH  = 1'h1;
    localparam int         STACK_DEPTH  = 4;
    localparam int         WR_BITS      = 5;
    localparam logic [4:0] STACK_RESET  = 5'h1F;
    localparam logic [8:0] CM_IDLE      = 9'h1FF;
    localparam logic [7:0] OR_RESET     = 8'hFF;
    localparam logic [8:0] INIT_DONE    = 9'h100;
    localparam logic [2:0] OP_CONNECT   = 3'h1;
    localparam logic [2:0] OP_DISC      = 3'h2;
    localparam logic [2:0] OP_INSERT    = 3'h3;
    localparam logic [2:0] OP_SAMPLE    = 3'h4;
    localparam logic [2:0] OP_CWORD     = 3'h5;
    localparam logic [2:0] OP_ZERO      = 3'h6;
    localparam logic [3:0] DR_DELAY_CYC = 4'h6;
    localparam logic [3:0] DR_PULSE_CYC = 4'h2;
    localparam int         STROBE_NS    = 200;
    localparam int         HOLD_NS      = 30;
    localparam int         GAP_NS       = 600;
    localparam logic [7:0] STROBE_CYC   = 8'((STROBE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] HOLD_CYC     = 8'((HOLD_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] GAP_CYC      = 8'((GAP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] ADDR_WRITE   = 8'h00;
    localparam logic [7:0] ADDR_READ    = 8'h04;
    localparam logic [7:0] ADDR_STATUS  = 8'h08;
    localparam int         CMD_BIT      = 8;
    localparam logic [7:0] BUS_PULLUP   = 8'hFF;
    typedef enum logic [1:0] {
        H_IDLE   = 2'b00,
        H_STROBE = 2'b01,
        H_HOLD   = 2'b10,
        H_GAP    = 2'b11
    } host_state_t;
endpackage

// file: pcm_host_if.sv
// Parallel host port between the switch matrix and its controller.
// The shared data bus is resolved here from both enables, with a pull-up.
`timescale 1ns/1ps
interface pcm_host_if;
    import pcm_pkg::*;
    logic       chip_select_a_n;
    logic       chip_select_b_n;
    logic       wr_n;
    logic       rd_n;
    logic       cmd_sel;
    logic [7:0] host_out;
    logic       host_oe;
    logic [7:0] dev_out;
    logic       dev_oe;
    logic       ready_error_flag_n;
    logic [7:0] bus;

    // Wire level of the shared bus
    assign bus = dev_oe ? dev_out : (host_oe ? host_out : BUS_PULLUP);

    modport device (input chip_select_a_n, chip_select_b_n, wr_n, rd_n, cmd_sel, bus,
                    output dev_out, dev_oe, ready_error_flag_n);
    modport host   (output chip_select_a_n, chip_select_b_n, wr_n, rd_n, cmd_sel,
                    output host_out, host_oe, input bus, ready_error_flag_n);
endinterface

// file: switch_matrix_dev.sv
// Time-slot switch matrix: 8 serial lines in and out, host port for control.
// Assumes master clock and frame sync pins asynchronous to pclk.
// Summary of operation
// - Any of 256 inputs to any output
// - Eight serial lines in and out
// - Frame of 32 or 24 channels
// - Frame timing aligned to 8 kHz sync
// - Connections held on chip, host edits them
// - Six host instructions incl. connect/disconnect
// - Open-drain outputs combine several matrices
// - Reads drive 8 bits, writes take 5
// - Bus bit zero is least significant
// - Bus released while reset held low
// - Command select high marks an opcode
// - Command select picks readback register
// - Transfers only with both selects low
// - Host ties one chip select low
// - Instructions 5, 6 pulse flag two cycles
// - Instruction 5 flag 5..14 cycles after write
// - Bit rate is master clock halved
// - Frame sync falling edge resets time bases
// - Reset sets readback registers high, memory disconnected
// - Write captured at write strobe rising edge
`timescale 1ns/1ps
module switch_matrix_dev (
    // Clock, reset, enable
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             ce,
    // Host port
    pcm_host_if.device            hp,
    // Serial side
    input  wire logic             mck,
    input  wire logic             sync_n,
    input  wire logic             frame_24,
    input  wire logic [7:0]       pcm_in,
    output logic      [7:0]       pcm_out,
    output logic      [7:0]       pcm_out_oe
);
    import pcm_pkg::*;
    localparam int SW = 23;

    logic [SW-1:0] s1_reg, s2_reg, s3_reg;
    logic [7:0]    bit_reg, bit_next;
    logic          div_reg, div_next;
    logic [7:0]    in_sh_reg  [LINES];
    logic [7:0]    in_sh_next [LINES];
    logic [7:0]    out_sh_reg [LINES];
    logic [7:0]    out_sh_next[LINES];
    logic [7:0]    sm [LINES][SLOTS_E1];
    logic [8:0]    cm [LINES][SLOTS_E1];
    logic [4:0]    stack_reg  [STACK_DEPTH];
    logic [4:0]    stack_next [STACK_DEPTH];
    logic [2:0]    op_reg, op_next;
    logic          pend_reg, pend_next, err_reg, err_next;
    logic [7:0]    or1_reg, or1_next, or2_reg, or2_next;
    logic [3:0]    dr_reg, dr_next;
    logic [8:0]    init_reg, init_next;
    logic [7:0]    dout_reg, dout_next;
    logic          doe_reg, doe_next, flag_n_reg, flag_n_next;
    logic          cm_we;
    logic [2:0]    cm_line;
    logic [4:0]    cm_slot;
    logic [8:0]    cm_d;
    logic          mck_rise, sync_fall, tick, wr_rise, sel2, sel3, init_busy;
    logic [4:0]    slot, nslot;
    logic [8:0]    cw;

    // Pin synchronisers; stage three feeds edge detection and write data capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= '1;
            s2_reg <= '1;
            s3_reg <= '1;
        end else if (ce) begin
            s1_reg <= {mck, sync_n, pcm_in, hp.chip_select_a_n, hp.chip_select_b_n,
                       hp.wr_n, hp.rd_n, hp.cmd_sel, hp.bus};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Pin field decode
    assign mck_rise  = s2_reg[22] & ~s3_reg[22];
    assign sync_fall = ~s2_reg[21] & s3_reg[21];
    assign sel2      = ~s2_reg[12] & ~s2_reg[11];
    assign sel3      = ~s3_reg[12] & ~s3_reg[11];
    assign wr_rise   = s2_reg[10] & ~s3_reg[10] & sel3;
    assign tick      = mck_rise & (div_reg == MCK_LAST_PH);
    assign slot      = bit_reg[7:3];
    assign init_busy = init_reg != INIT_DONE;

    // Time base: bit counter wraps per frame format, sync restarts it
    always_comb begin
        div_next = div_reg;
        bit_next = bit_reg;
        nslot    = slot + 5'h1;
        if ((bit_reg | 8'h07) == (frame_24 ? LAST_BIT_T1 : LAST_BIT_E1))
            nslot = '0;
        if (sync_fall) begin
            div_next = '0;
            bit_next = '0;
        end else if (mck_rise) begin
            div_next = ~div_reg;
            if (tick)
                bit_next = (bit_reg == (frame_24 ? LAST_BIT_T1 : LAST_BIT_E1)) ?
                           8'h00 : bit_reg + 8'h01;
        end
    end

    // Serial shifters per line; outputs reload at slot boundaries
    for (genvar l = 0; l < LINES; l++) begin : g_line
        logic [8:0] ent;
        assign ent = cm[l][nslot];
        always_comb begin
            in_sh_next[l]  = in_sh_reg[l];
            out_sh_next[l] = out_sh_reg[l];
            if (tick) begin
                in_sh_next[l] = {in_sh_reg[l][6:0], s2_reg[13+l]};
                if (bit_reg[2:0] == LAST_BITPOS)
                    out_sh_next[l] = ent[8] ? ent[7:0] : sm[ent[7:5]][ent[4:0]];
                else
                    out_sh_next[l] = {out_sh_reg[l][6:0], 1'b1};
            end
        end
        assign pcm_out[l]    = 1'b0;
        assign pcm_out_oe[l] = ~out_sh_reg[l][7];
    end

    // Time base and shifter registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= '0;
            bit_reg <= '0;
            for (int l = 0; l < LINES; l++) begin
                in_sh_reg[l]  <= '1;
                out_sh_reg[l] <= '1;
            end
        end else if (ce) begin
            div_reg <= div_next;
            bit_reg <= bit_next;
            in_sh_reg  <= in_sh_next;
            out_sh_reg <= out_sh_next;
        end
    end

    // Speech memory: completed input bytes stored per line and slot
    always_ff @(posedge pclk) begin
        if (ce && tick && bit_reg[2:0] == LAST_BITPOS)
            for (int l = 0; l < LINES; l++)
                sm[l][slot] <= {in_sh_reg[l][6:0], s2_reg[13+l]};
    end

    // Host port: stacking, decode, execution, readback and flag
    always_comb begin
        stack_next = stack_reg;
        op_next    = op_reg;
        pend_next  = pend_reg & init_busy;
        err_next   = err_reg;
        or1_next   = or1_reg;
        or2_next   = or2_reg;
        dr_next    = (dr_reg != '0) ? dr_reg - 4'h1 : dr_reg;
        init_next  = init_busy ? init_reg + 9'h001 : init_reg;
        cm_we      = init_busy;
        cm_line    = init_reg[7:5];
        cm_slot    = init_reg[4:0];
        cm_d       = CM_IDLE;
        cw         = cm[stack_reg[3][2:0]][stack_reg[2]];
        if (wr_rise && !s3_reg[8]) begin
            for (int i = STACK_DEPTH - 1; i > 0; i--)
                stack_next[i] = stack_reg[i-1];
            stack_next[0] = s3_reg[WR_BITS-1:0];
        end else if (wr_rise) begin
            op_next = s3_reg[2:0];
            if (s3_reg[2:0] >= OP_CONNECT && s3_reg[2:0] <= OP_ZERO && s3_reg[4:3] == '0) begin
                err_next  = 1'b0;
                pend_next = 1'b1;
            end else
                err_next = 1'b1;
        end
        if (pend_reg && !init_busy) begin
            or2_next = {4'h0, 1'b0, op_reg};
            case (op_reg)
                OP_CONNECT: begin
                    cm_we   = 1'b1;
                    cm_line = stack_reg[3][2:0];
                    cm_slot = stack_reg[2];
                    cm_d    = {1'b0, stack_reg[1][2:0], stack_reg[0]};
                end
                OP_DISC: begin
                    cm_we   = 1'b1;
                    cm_line = stack_reg[1][2:0];
                    cm_slot = stack_reg[0];
                end
                OP_INSERT: begin
                    cm_we   = 1'b1;
                    cm_line = stack_reg[3][2:0];
                    cm_slot = stack_reg[2];
                    cm_d    = {1'b1, stack_reg[1][2:0], stack_reg[0]};
                end
                OP_SAMPLE: begin
                    cw       = cm[stack_reg[1][2:0]][stack_reg[0]];
                    or1_next = cw[8] ? cw[7:0] : sm[cw[7:5]][cw[4:0]];
                end
                OP_CWORD: begin
                    cw       = cm[stack_reg[1][2:0]][stack_reg[0]];
                    or1_next = cw[7:0];
                    or2_next = {4'h0, cw[8], op_reg};
                    dr_next  = DR_DELAY_CYC + DR_PULSE_CYC;
                end
                default: begin
                    or1_next = sm[stack_reg[0][2:0]][5'h00];
                    dr_next  = DR_DELAY_CYC + DR_PULSE_CYC;
                end
            endcase
        end
        flag_n_next = ~(err_reg | (dr_reg != '0 && dr_reg <= DR_PULSE_CYC));
        doe_next    = ~s2_reg[9] & sel2;
        dout_next   = s2_reg[8] ? or2_reg : or1_reg;
    end

    // Host port registers; stack, opcode, readback, data out and flag set high at reset, the rest low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < STACK_DEPTH; i++)
                stack_reg[i] <= STACK_RESET;
            op_reg     <= '1;
            pend_reg   <= '0;
            err_reg    <= '0;
            or1_reg    <= OR_RESET;
            or2_reg    <= OR_RESET;
            dr_reg     <= '0;
            init_reg   <= '0;
            dout_reg   <= '1;
            doe_reg    <= '0;
            flag_n_reg <= '1;
        end else if (ce) begin
            stack_reg  <= stack_next;
            op_reg     <= op_next;
            pend_reg   <= pend_next;
            err_reg    <= err_next;
            or1_reg    <= or1_next;
            or2_reg    <= or2_next;
            dr_reg     <= dr_next;
            init_reg   <= init_next;
            dout_reg   <= dout_next;
            doe_reg    <= doe_next;
            flag_n_reg <= flag_n_next;
        end
    end

    // Connection memory: init sweep has priority over instructions
    always_ff @(posedge pclk) begin
        if (ce && cm_we)
            cm[cm_line][cm_slot] <= cm_d;
    end

    assign hp.dev_out            = dout_reg;
    assign hp.dev_oe             = doe_reg;
    assign hp.ready_error_flag_n = flag_n_reg;
endmodule

// file: switch_matrix_host.sv
// Controller end: APB slave that turns register writes into port strobes.
// Assumes the matrix port shares pclk; returning pins are synchronised.
`timescale 1ns/1ps
module switch_matrix_host (
    // Clock, reset, enable
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             ce,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Matrix port
    pcm_host_if.host              hp
);
    import pcm_pkg::*;

    host_state_t st_reg, st_next;
    logic [7:0]  cnt_reg, cnt_next, byte_reg, byte_next, rd_reg, rd_next;
    logic        cmd_reg, cmd_next, isrd_reg, isrd_next;
    logic [8:0]  s1_reg, s2_reg;
    logic        launch, go;

    // Returning pins pass two flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= '1;
            s2_reg <= '1;
        end else if (ce) begin
            s1_reg <= {hp.ready_error_flag_n, hp.bus};
            s2_reg <= s1_reg;
        end
    end

    // A launch stalls while a transfer is still running
    assign launch  = psel & penable & pwrite & (paddr == ADDR_WRITE || paddr == ADDR_READ);
    assign go      = launch & (st_reg == H_IDLE) & ce;
    assign pready  = ~(launch & (st_reg != H_IDLE));
    assign pslverr = 1'b0;

    // Port sequencer: strobe, hold, recovery gap
    always_comb begin
        st_next   = st_reg;
        cnt_next  = cnt_reg + 8'h01;
        byte_next = byte_reg;
        cmd_next  = cmd_reg;
        isrd_next = isrd_reg;
        rd_next   = rd_reg;
        case (st_reg)
            H_IDLE: begin
                cnt_next = '0;
                if (go) begin
                    st_next   = H_STROBE;
                    isrd_next = (paddr == ADDR_READ);
                    byte_next = pwdata[7:0];
                    cmd_next  = (paddr == ADDR_READ) ? pwdata[0] : pwdata[CMD_BIT];
                end
            end
            H_STROBE: if (cnt_reg == STROBE_CYC - 8'h01) begin
                st_next  = H_HOLD;
                cnt_next = '0;
                if (isrd_reg)
                    rd_next = s2_reg[7:0];
            end
            H_HOLD: if (cnt_reg == HOLD_CYC - 8'h01) begin
                st_next  = H_GAP;
                cnt_next = '0;
            end
            default: if (cnt_reg == GAP_CYC - 8'h01) begin
                st_next  = H_IDLE;
                cnt_next = '0;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg   <= H_IDLE;
            cnt_reg  <= '0;
            byte_reg <= '0;
            cmd_reg  <= '0;
            isrd_reg <= '0;
            rd_reg   <= '0;
        end else if (ce) begin
            st_reg   <= st_next;
            cnt_reg  <= cnt_next;
            byte_reg <= byte_next;
            cmd_reg  <= cmd_next;
            isrd_reg <= isrd_next;
            rd_reg   <= rd_next;
        end
    end

    // Pin drive; second select held low for good
    assign hp.chip_select_a_n = ~(st_reg == H_STROBE || st_reg == H_HOLD);
    assign hp.chip_select_b_n = 1'b0;
    assign hp.wr_n            = ~(st_reg == H_STROBE && !isrd_reg);
    assign hp.rd_n            = ~(st_reg == H_STROBE && isrd_reg);
    assign hp.cmd_sel         = cmd_reg;
    assign hp.host_out        = byte_reg;
    assign hp.host_oe         = ~isrd_reg & (st_reg == H_STROBE || st_reg == H_HOLD);

    // Status readback
    always_comb begin
        prdata = '0;
        if (paddr == ADDR_STATUS)
            prdata = {16'h0000, rd_reg, 6'h00, ~s2_reg[8], st_reg != H_IDLE};
    end
endmodule

// file: pcm_host_port_assertions.sv
// Checker for the parallel host port between controller and matrix.
// Assumes it is instantiated beside the interface, one pclk domain.
`timescale 1ns/1ps
module pcm_host_port_checker (
    // Clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // Host port lines
    input wire logic       chip_select_a_n,
    input wire logic       chip_select_b_n,
    input wire logic       wr_n,
    input wire logic       rd_n,
    input wire logic       cmd_sel,
    input wire logic [7:0] host_out,
    input wire logic       host_oe,
    input wire logic [7:0] dev_out,
    input wire logic       dev_oe,
    input wire logic       ready_error_flag_n
);
    import pcm_pkg::*;
    logic [2:0] op_reg;
    logic [2:0] op_next;

    // Last opcode seen on a strobe marked as command
    always_comb begin
        op_next = op_reg;
        if (!wr_n && cmd_sel) op_next = host_out[2:0];
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) op_reg <= 3'h0;
        else op_reg <= op_next;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // End of a strobe carrying a control word opcode
    sequence s_cword_end;
        $rose(wr_n) && cmd_sel && op_reg == OP_CWORD;
    endsequence
    // Start of the flag pulse after instruction 5 or 6
    sequence s_pulse_start;
        $fell(ready_error_flag_n) && (op_reg == OP_CWORD || op_reg == OP_ZERO);
    endsequence

    a_bus_free_reset: assert property (!$past(presetn) |-> !dev_oe)
        else $error("bus driven right after reset");
    a_flag_idle_reset: assert property (!$past(presetn) |-> ready_error_flag_n && dev_out == OR_RESET)
        else $error("port outputs not high after reset");
    a_drive_needs_sel: assert property ($rose(dev_oe) |-> $past(!rd_n && !chip_select_a_n && !chip_select_b_n, 2))
        else $error("bus driven without selected read");
    a_no_contention: assert property (!(dev_oe && host_oe))
        else $error("both ends drive the bus");
    a_host_off_read: assert property (!rd_n |-> !host_oe)
        else $error("host drives bus during read");
    a_host_on_write: assert property (!wr_n |-> host_oe && !chip_select_a_n)
        else $error("write strobe without driven bus");
    a_one_sel_tied: assert property (!chip_select_b_n)
        else $error("second select not held low");
    a_write_held: assert property (!wr_n && $past(!wr_n) |-> $stable(host_out) && $stable(cmd_sel))
        else $error("write byte changed under strobe");
    a_strobe_width: assert property ($fell(wr_n) |-> (!wr_n) [*8])
        else $error("write strobe too short");
    a_cword_flag: assert property (s_cword_end |-> ##[5:14] !ready_error_flag_n)
        else $error("flag late after control word");
    a_pulse_short: assert property (s_pulse_start |-> ##2 ready_error_flag_n)
        else $error("flag pulse longer than two cycles");
endmodule

// file: tb_pcm_switch_matrix_host_port.sv
// Bench joining controller and matrix through the host port interface.
// Assumes APB register map and port timing of the controller as delivered.
`timescale 1ns/1ps
module tb_pcm_switch_matrix_host_port;
    import pcm_pkg::*;
    logic        pclk = 1'h0;
    logic        presetn = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        mck = 1'h0;
    logic        sync_n = 1'h1;
    logic [7:0]  pcm_in = 8'h00;
    logic [7:0]  pcm_out;
    logic [7:0]  pcm_out_oe;
    logic        frame_24 = 1'h0;
    logic [11:0] tick = 12'h000;
    logic [31:0] r;
    logic [7:0]  v;
    int          fail_count = 0;
    int          n_compared = 0;

    pcm_host_if hp_if();
    switch_matrix_host i_switch_matrix_host (.pclk(pclk), .presetn(presetn), .ce(1'h1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .hp(hp_if.host));
    switch_matrix_dev i_switch_matrix_dev (.pclk(pclk), .presetn(presetn), .ce(1'h1),
        .hp(hp_if.device), .mck(mck), .sync_n(sync_n), .frame_24(frame_24), .pcm_in(pcm_in),
        .pcm_out(pcm_out), .pcm_out_oe(pcm_out_oe));
    pcm_host_port_checker i_pcm_host_port_checker (.pclk(pclk), .presetn(presetn),
        .chip_select_a_n(hp_if.chip_select_a_n), .chip_select_b_n(hp_if.chip_select_b_n),
        .wr_n(hp_if.wr_n), .rd_n(hp_if.rd_n), .cmd_sel(hp_if.cmd_sel),
        .host_out(hp_if.host_out), .host_oe(hp_if.host_oe), .dev_out(hp_if.dev_out),
        .dev_oe(hp_if.dev_oe), .ready_error_flag_n(hp_if.ready_error_flag_n));

    always #2.5 pclk = ~pclk;
    // Serial side: master clock toggles every 3 cycles, one frame of 256 or 192 bits
    always @(posedge pclk) begin
        tick <= (tick == (frame_24 ? 12'h8FF : 12'hBFF)) ? 12'h000 : tick + 12'h001;
        if (tick % 12'h003 == 12'h000) mck <= ~mck;
        sync_n <= !(tick < 12'h006);
        pcm_in <= tick[11:4];
    end

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask
    // A bound used up counts as a mismatch and ends the run
    task automatic stall(input logic hit);
        if (hit) begin
            chk(32'h0, 32'h1);
            print_verdict();
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'h1 && i < 1000);
        r = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
        stall(i >= 1000);
    endtask
    // Poll status until the port transfer has finished
    task automatic idle;
        int i;
        i = 0;
        do begin
            apb(1'h0, ADDR_STATUS, 32'h0);
            i++;
        end while (r[0] !== 1'h0 && i < 200);
        stall(i >= 200);
    endtask
    task automatic pw(input logic c, input logic [7:0] b);
        apb(1'h1, ADDR_WRITE, {23'h0, c, b});
        idle();
    endtask
    task automatic rd_or(input logic c);
        apb(1'h1, ADDR_READ, {31'h0, c});
        idle();
        v = r[15:8];
    endtask
    // Opcode write, then flag delay from strobe end and pulse width
    task automatic t_flag(input logic [2:0] op, input int lo, input int hi);
        int n;
        int w;
        apb(1'h1, ADDR_WRITE, {23'h0, 1'h1, 5'h00, op});
        n = 0;
        while (hp_if.wr_n !== 1'h0 && n < 100) begin @(posedge pclk); n++; end
        while (hp_if.wr_n !== 1'h1 && n < 200) begin @(posedge pclk); n++; end
        stall(n >= 200);
        n = 0;
        while (hp_if.ready_error_flag_n !== 1'h0 && n < 4000) begin @(posedge pclk); n++; end
        stall(n >= 4000);
        w = 0;
        while (hp_if.ready_error_flag_n === 1'h0 && w < 10) begin @(posedge pclk); w++; end
        chk({31'h0, n >= lo && n <= hi}, 32'h1);
        chk({31'h0, w >= 1 && w <= 2}, 32'h1);
        idle();
    endtask
    task automatic cword(input logic [7:0] l, input logic [7:0] s);
        pw(1'h0, l);
        pw(1'h0, s);
        t_flag(OP_CWORD, 5, 14);
    endtask

    task automatic t_reset;
        chk({24'h0, hp_if.bus}, 32'hFF);
        chk({31'h0, hp_if.ready_error_flag_n}, 32'h1);
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        repeat (300) @(posedge pclk);
        rd_or(1'h0);
        chk({24'h0, v}, 32'hFF);
        rd_or(1'h1);
        chk({24'h0, v}, 32'hFF);
        apb(1'h0, 8'h0C, 32'h0);
        chk(r, 32'h0);
    endtask
    task automatic t_cword;
        cword(8'h03, 8'h07);
        rd_or(1'h0);
        chk({24'h0, v}, 32'hFF);
        rd_or(1'h1);
        chk({24'h0, v}, {24'h0, 4'h0, 1'h1, OP_CWORD});
    endtask
    task automatic t_insert;
        pw(1'h0, 8'h02);
        pw(1'h0, 8'h05);
        pw(1'h0, 8'h05);
        pw(1'h0, 8'h05);
        pw(1'h1, {5'h00, OP_INSERT});
        cword(8'h02, 8'h05);
        rd_or(1'h0);
        chk({24'h0, v}, 32'hA5);
    endtask
    task automatic t_connect;
        pw(1'h0, 8'h02);
        pw(1'h0, 8'h05);
        pw(1'h0, 8'h01);
        pw(1'h0, 8'h09);
        pw(1'h1, {5'h00, OP_CONNECT});
        cword(8'h02, 8'h05);
        rd_or(1'h1);
        chk({24'h0, v}, {24'h0, 5'h00, OP_CWORD});
        rd_or(1'h0);
        chk({24'h0, v}, 32'h29);
        pw(1'h0, 8'h02);
        pw(1'h0, 8'h05);
        pw(1'h1, {5'h00, OP_DISC});
        cword(8'h02, 8'h05);
        rd_or(1'h1);
        chk({24'h0, v}, {24'h0, 5'h01, OP_CWORD});
        pw(1'h1, {5'h00, OP_SAMPLE});
        rd_or(1'h1);
        chk({24'h0, v}, {24'h0, 5'h00, OP_SAMPLE});
    endtask
    task automatic t_zero;
        pw(1'h0, 8'h01);
        t_flag(OP_ZERO, 0, 3999);
        rd_or(1'h1);
        chk({24'h0, v}, {24'h0, 5'h00, OP_ZERO});
    endtask
    // Inserted byte 8'hA5 on line 2: four low bits of 12 cycles per frame
    task automatic t_serial(input logic f24, input int frame);
        int c;
        frame_24 <= f24;
        repeat (2 * frame) @(posedge pclk);
        c = 0;
        repeat (frame) begin
            @(posedge pclk);
            if (pcm_out_oe[2] === 1'h1) c++;
        end
        chk(c, 32'h30);
        chk({24'h0, pcm_out}, 32'h0);
    endtask
    // Invalid opcode holds the flag low until a valid one arrives
    task automatic t_bad;
        pw(1'h1, 8'h07);
        chk({31'h0, r[1]}, 32'h1);
        pw(1'h1, {5'h00, OP_SAMPLE});
        chk({31'h0, r[1]}, 32'h0);
    endtask

    initial begin
        repeat (7) @(posedge pclk);
        t_reset();
        t_cword();
        t_insert();
        t_serial(1'h0, 32'hC00);
        t_serial(1'h1, 32'h900);
        t_connect();
        t_zero();
        t_bad();
        print_verdict();
    end
endmodule
